// [rtl/grp_pkg.sv]
/*
  Shared constants for the gamma reference two-wire link: device address,
  channel layout, timing counts and the controller's register map.
  Assumes a 10 MHz system clock on both ends.
*/
package grp_pkg;
  // system clock and serial timing
  localparam int SYS_CLK_NS = 100;
  localparam int SCL_MAX_KHZ = 400;
  localparam int SCL_HALF_NS = 1000000 / (2 * SCL_MAX_KHZ);
  localparam logic [4:0] HALF_CYC = 5'((SCL_HALF_NS + SYS_CLK_NS - 1) / SYS_CLK_NS);
  localparam logic [4:0] SDA_SET_AT = HALF_CYC - 5'h3;
  localparam int BUS_FREE_NS = 1300;
  localparam logic [4:0] BUS_FREE_CYC = 5'((BUS_FREE_NS + SYS_CLK_NS - 1) / SYS_CLK_NS);

  // device address and code store layout
  localparam logic [5:0] ADDR_HIGH_BITS = 6'h3A;
  localparam logic [3:0] NUM_CHANNELS = 4'hE;
  localparam int UPPER_COUNT = 7;
  localparam int CTRL_WR_BANK_BIT = 1;
  localparam int CTRL_RD_BANK_BIT = 2;

  // controller registers, classic Wishbone, byte addresses
  localparam int WB_ADR_W = 4;
  localparam logic [3:0] CMD_OFS = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h4;
  localparam int CMD_START_BIT = 8;
  localparam int CMD_STOP_BIT = 9;
  localparam int CMD_READ_BIT = 10;
  localparam int CMD_ACK_BIT = 11;
  localparam int STS_BUSY_BIT = 0;
  localparam int STS_ACK_BIT = 1;
  localparam int STS_RX_LSB = 8;
endpackage

// [rtl/grp_i2c_if.sv]
/*
  Two-wire bus between the controller end and the gamma reference end.
  Both lines are open drain with a pull-up modelled here from the enables.
*/
`timescale 1ns/10ps
interface grp_i2c_if;
  // controller drives
  logic sclHostOut;
  logic sclHostOe;
  logic sdaHostOut;
  logic sdaHostOe;
  // device drives
  logic sdaDevOut;
  logic sdaDevOe;
  // resolved line levels, pulled high unless someone drives low
  logic sclLine;
  logic sdaLine;

  assign sclLine = !(sclHostOe && !sclHostOut);
  assign sdaLine = !((sdaHostOe && !sdaHostOut) || (sdaDevOe && !sdaDevOut));

  modport host (output sclHostOut, sclHostOe, sdaHostOut, sdaHostOe, input sclLine, sdaLine);
  modport dev (output sdaDevOut, sdaDevOe, input sclLine, sdaLine);
endinterface

// [rtl/grp_ref_slave.sv]
/*
  Gamma reference serial slave: decodes start and stop, takes the address,
  control and data bytes, keeps two banks of fourteen codes and drives the
  selected bank to the outputs. Assumes the bus master keeps to the
  line timing; all pins are asynchronous and are synchronised here.
*/
`timescale 1ns/10ps

// Function
// - mode pin high standard, low register
// - answer address 74h or 75h by pin
// - curve pin picks bank driving outputs
// - one 8-bit code per fourteen channels
// - channels 8-14 lower, 1-7 upper group
// - serial clock at most 400 kHz
// - start is data falling, clock high
// - stop is data rising, clock high
// - only master makes start and stop
// - busy from start until after stop
// - both lines released when idle
// - data stable during clock high
// - data changes only while clock low
// - every byte is eight bits
// - unlimited bytes between start and stop
// - most significant bit first
// - receiver pulls low in acknowledge clock
// - upper six address bits fixed 111010
// - eighth bit zero write, one read
// - control bit picks write bank
module grp_ref_slave
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // serial bus
  grp_i2c_if.dev bus,
  // strap and select pins
  input wire logic transferModePin,
  input wire logic addressLowBitPin,
  input wire logic curveSelPin,
  // reference codes
  output logic [grp_pkg::UPPER_COUNT-1:0][7:0] upperRangeOutputs,
  output logic [grp_pkg::UPPER_COUNT-1:0][7:0] lowerRangeOutputs,
  output logic busBusy
);
  import grp_pkg::*;

  typedef enum logic [2:0]
  {
    D_IDLE = 3'b000,
    D_ADDR = 3'b001,
    D_CTRL = 3'b010,
    D_INDEX = 3'b011,
    D_DATA = 3'b100,
    D_READ = 3'b101,
    D_IGNORE = 3'b110
  } grp_dev_state_t;

  typedef struct packed {
    logic [1:0] sclSync;
    logic [1:0] sdaSync;
    logic [1:0] modeSync;
    logic [1:0] addrSync;
    logic [1:0] curveSync;
    logic sclPrev;
    logic sdaPrev;
    grp_dev_state_t state;
    logic [3:0] bitCnt;
    logic ackPhase;
    logic masterNack;
    logic [7:0] shift;
    logic [7:0] txByte;
    logic [3:0] idx;
    logic wrBank;
    logic rdBank;
    logic driveLow;
    logic busy;
    logic [4:0] freeCnt;
    logic [1:0][13:0][7:0] bank;
    logic [13:0][7:0] outCodes;
  } grp_dev_st_t;

  grp_dev_st_t st_r;
  grp_dev_st_t st_nxt;
  logic sclS;
  logic sdaS;
  logic sclRise;
  logic sclFall;
  logic startDet;
  logic stopDet;

  // code lookup, zero past the last channel so long reads stay defined
  function automatic logic [7:0] grp_code_at(input logic [1:0][13:0][7:0] b, input logic sel,
                                             input logic [3:0] i);
    if (i < NUM_CHANNELS)
      grp_code_at = b[sel][i];
    else
      grp_code_at = 8'h00;
  endfunction

  // saturating channel step, parks on the count once all are done
  function automatic logic [3:0] grp_next_idx(input logic [3:0] i);
    if (i < NUM_CHANNELS)
      grp_next_idx = i + 4'h1;
    else
      grp_next_idx = NUM_CHANNELS;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // line sampling: only second sync stages feed the decode
  assign sclS = st_r.sclSync[1];
  assign sdaS = st_r.sdaSync[1];
  assign sclRise = sclS & ~st_r.sclPrev;
  assign sclFall = ~sclS & st_r.sclPrev;
  assign startDet = sclS & st_r.sclPrev & st_r.sdaPrev & ~sdaS;
  assign stopDet = sclS & st_r.sclPrev & ~st_r.sdaPrev & sdaS;

  ////////////////////////////////////////////////////////////////////////////
  // next state of the whole slave
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.sclSync = {st_r.sclSync[0], bus.sclLine};
    st_nxt.sdaSync = {st_r.sdaSync[0], bus.sdaLine};
    st_nxt.modeSync = {st_r.modeSync[0], transferModePin};
    st_nxt.addrSync = {st_r.addrSync[0], addressLowBitPin};
    st_nxt.curveSync = {st_r.curveSync[0], curveSelPin};
    st_nxt.sclPrev = sclS;
    st_nxt.sdaPrev = sdaS;
    // busy lingers a fixed free time past the stop
    if (st_r.freeCnt != 5'h0)
    begin
      st_nxt.freeCnt = st_r.freeCnt - 5'h1;
      if (st_r.freeCnt == 5'h1)
        st_nxt.busy = 1'b0;
    end
    if (startDet)
    begin
      // a start always resynchronises, even mid-byte or while ignoring
      st_nxt.busy = 1'b1;
      st_nxt.freeCnt = 5'h0;
      st_nxt.state = D_ADDR;
      st_nxt.bitCnt = 4'h0;
      st_nxt.ackPhase = 1'b0;
      st_nxt.driveLow = 1'b0;
    end
    else if (stopDet)
    begin
      st_nxt.state = D_IDLE;
      st_nxt.driveLow = 1'b0;
      st_nxt.freeCnt = BUS_FREE_CYC;
    end
    else if (st_r.state != D_IDLE && st_r.state != D_IGNORE)
    begin
      // sample on the rising clock edge: data is stable through the high phase
      if (sclRise)
      begin
        if (!st_r.ackPhase)
        begin
          st_nxt.shift = {st_r.shift[6:0], sdaS};
          st_nxt.bitCnt = st_r.bitCnt + 4'h1;
        end
        else
          st_nxt.masterNack = sdaS;
      end
      // every change of our own drive waits for a falling clock edge
      if (sclFall)
      begin
        if (st_r.ackPhase)
        begin
          st_nxt.ackPhase = 1'b0;
          st_nxt.bitCnt = 4'h0;
          st_nxt.driveLow = 1'b0;
          if (st_r.state == D_READ)
          begin
            if (st_r.masterNack)
              st_nxt.state = D_IGNORE; // release so the master can stop
            else
              st_nxt.driveLow = ~st_r.txByte[7];
          end
        end
        else if (st_r.bitCnt == 4'h8)
        begin
          st_nxt.ackPhase = 1'b1;
          st_nxt.driveLow = (st_r.state != D_READ);
          case (st_r.state)
            D_ADDR:
            begin
              if (st_r.shift[7:1] == {ADDR_HIGH_BITS, st_r.addrSync[1]})
              begin
                if (st_r.shift[0])
                begin
                  st_nxt.state = D_READ;
                  // register mode resumes at the last pointed channel
                  if (st_r.modeSync[1])
                    st_nxt.idx = 4'h0;
                  st_nxt.txByte = grp_code_at(st_r.bank, st_r.rdBank,
                                              st_r.modeSync[1] ? 4'h0 : st_r.idx);
                end
                else
                  st_nxt.state = D_CTRL;
              end
              else
              begin
                st_nxt.state = D_IGNORE;
                st_nxt.driveLow = 1'b0;
              end
            end
            D_CTRL:
            begin
              st_nxt.wrBank = st_r.shift[CTRL_WR_BANK_BIT];
              st_nxt.rdBank = st_r.shift[CTRL_RD_BANK_BIT];
              st_nxt.idx = 4'h0;
              st_nxt.state = st_r.modeSync[1] ? D_DATA : D_INDEX;
            end
            D_INDEX:
            begin
              // pointer past the last channel parks and drops further data
              st_nxt.idx = (st_r.shift < {4'h0, NUM_CHANNELS}) ? st_r.shift[3:0] : NUM_CHANNELS;
              st_nxt.state = D_DATA;
            end
            D_DATA:
            begin
              if (st_r.idx < NUM_CHANNELS)
                st_nxt.bank[st_r.wrBank][st_r.idx] = st_r.shift;
              st_nxt.idx = grp_next_idx(st_r.idx);
            end
            D_READ:
            begin
              // fetch the following code now, sent after the master's ack
              st_nxt.idx = grp_next_idx(st_r.idx);
              st_nxt.txByte = grp_code_at(st_r.bank, st_r.rdBank, grp_next_idx(st_r.idx));
            end
            default:
            begin
              st_nxt.state = D_IGNORE;
              st_nxt.driveLow = 1'b0;
            end
          endcase
        end
        else if (st_r.state == D_READ)
          st_nxt.driveLow = ~st_r.txByte[~st_r.bitCnt[2:0]];
      end
    end
    // the curve pin picks which bank the outputs show
    st_nxt.outCodes = st_r.bank[st_r.curveSync[1]];
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs: open drain, low or released
  assign bus.sdaDevOut = 1'b0;
  assign bus.sdaDevOe = st_r.driveLow;
  assign upperRangeOutputs = st_r.outCodes[UPPER_COUNT-1:0];
  assign lowerRangeOutputs = st_r.outCodes[13:UPPER_COUNT];
  assign busBusy = st_r.busy;
endmodule

// [rtl/grp_bus_master.sv]
/*
  Two-wire bus controller: software writes one byte command at a time over
  classic Wishbone; the controller clocks the byte out or in with optional
  start and stop and reports the acknowledge and read data.
  Assumes the slave never stretches the clock.
*/
`timescale 1ns/10ps
module grp_bus_master
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [grp_pkg::WB_ADR_W-1:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // serial bus
  grp_i2c_if.host bus
);
  import grp_pkg::*;

  typedef enum logic [2:0]
  {
    H_IDLE = 3'b000,
    H_START1 = 3'b001,
    H_START2 = 3'b010,
    H_LOW = 3'b011,
    H_HIGH = 3'b100,
    H_STOP1 = 3'b101,
    H_STOP2 = 3'b110
  } grp_host_state_t;

  typedef struct packed {
    logic [1:0] sdaSync;
    grp_host_state_t state;
    logic [4:0] cnt;
    logic [3:0] bitIdx;
    logic [7:0] tx;
    logic [7:0] rx;
    logic doStop;
    logic isRead;
    logic sendAck;
    logic ackGot;
    logic sclLow;
    logic sdaLow;
    logic wbAck;
    logic [31:0] rdData;
  } grp_host_st_t;

  grp_host_st_t st_r;
  grp_host_st_t st_nxt;
  logic req;
  logic halfDone;

  assign req = cyc_i & stb_i & ~st_r.wbAck;
  assign halfDone = (st_r.cnt == 5'h0);

  ////////////////////////////////////////////////////////////////////////////
  // next state: register access, then the bit sequencer
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.sdaSync = {st_r.sdaSync[0], bus.sdaLine};
    st_nxt.wbAck = req; // one wait state, ack drops the cycle after
    if (req)
    begin
      st_nxt.rdData = 32'h0;
      if (!we_i && adr_i == STATUS_OFS)
      begin
        st_nxt.rdData[STS_BUSY_BIT] = (st_r.state != H_IDLE);
        st_nxt.rdData[STS_ACK_BIT] = st_r.ackGot;
        st_nxt.rdData[STS_RX_LSB+:8] = st_r.rx;
      end
      // a command while busy is dropped; software polls busy first
      if (we_i && adr_i == CMD_OFS && sel_i[1:0] == 2'h3 && st_r.state == H_IDLE)
      begin
        st_nxt.tx = dat_i[7:0];
        st_nxt.doStop = dat_i[CMD_STOP_BIT];
        st_nxt.isRead = dat_i[CMD_READ_BIT];
        st_nxt.sendAck = dat_i[CMD_ACK_BIT];
        st_nxt.bitIdx = 4'h0;
        st_nxt.cnt = HALF_CYC - 5'h1;
        st_nxt.state = dat_i[CMD_START_BIT] ? H_START1 : H_LOW;
        st_nxt.sdaLow = 1'b0;
        st_nxt.sclLow = ~dat_i[CMD_START_BIT];
      end
    end
    if (st_r.state != H_IDLE)
      st_nxt.cnt = halfDone ? HALF_CYC - 5'h1 : st_r.cnt - 5'h1;
    case (st_r.state)
      H_IDLE:
      begin
        // a new command is taken by the register access above; the default
        // branch must not see idle, or it would cancel that command
      end
      H_START1:
      begin
        // data and clock are both released when the command is taken; data falls once the half period ends
        if (st_r.cnt == SDA_SET_AT)
          st_nxt.sclLow = 1'b0;
        if (halfDone)
        begin
          st_nxt.sdaLow = 1'b1;
          st_nxt.state = H_START2;
        end
      end
      H_START2:
        if (halfDone)
        begin
          st_nxt.sclLow = 1'b1;
          st_nxt.state = H_LOW;
        end
      H_LOW:
      begin
        st_nxt.sclLow = 1'b1;
        // data moves three cycles after the clock falls, never while high
        if (st_r.cnt == SDA_SET_AT)
        begin
          if (st_r.bitIdx[3])
            st_nxt.sdaLow = st_r.isRead & st_r.sendAck;
          else
            st_nxt.sdaLow = ~st_r.isRead & ~st_r.tx[~st_r.bitIdx[2:0]];
        end
        if (halfDone)
        begin
          st_nxt.sclLow = 1'b0;
          st_nxt.state = H_HIGH;
        end
      end
      H_HIGH:
        if (halfDone)
        begin
          if (st_r.bitIdx[3])
          begin
            st_nxt.ackGot = ~st_r.sdaSync[1];
            st_nxt.sclLow = 1'b1;
            st_nxt.state = H_STOP1;
          end
          else
          begin
            st_nxt.rx = {st_r.rx[6:0], st_r.sdaSync[1]};
            st_nxt.bitIdx = st_r.bitIdx + 4'h1;
            st_nxt.sclLow = 1'b1;
            st_nxt.state = H_LOW;
          end
        end
      H_STOP1:
      begin
        if (st_r.cnt == SDA_SET_AT)
          st_nxt.sdaLow = st_r.doStop;
        if (halfDone)
        begin
          // without a stop the clock is parked low for the next byte
          st_nxt.sclLow = ~st_r.doStop;
          st_nxt.state = st_r.doStop ? H_STOP2 : H_IDLE;
        end
      end
      H_STOP2:
        if (halfDone)
        begin
          st_nxt.sdaLow = 1'b0;
          st_nxt.state = H_IDLE;
        end
      default:
        st_nxt.state = H_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign bus.sclHostOut = 1'b0;
  assign bus.sclHostOe = st_r.sclLow;
  assign bus.sdaHostOut = 1'b0;
  assign bus.sdaHostOe = st_r.sdaLow;
  assign dat_o = st_r.rdData;
  assign ack_o = st_r.wbAck;
endmodule

// [bench/grp_link_chk.sv]
/*
  Line checker for the two-wire link between controller and reference slave.
  Assumes the 10 MHz system clock and the shared interface signals as inputs.
*/
`timescale 1ns/10ps
module grp_link_chk
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // drive enables
  input wire logic sclHostOe,
  input wire logic sdaDevOe,
  // resolved lines
  input wire logic sclLine,
  input wire logic sdaLine
);
  logic sclPrev_r;
  logic seenRise_r;
  logic [7:0] periodCnt_r;
  logic [7:0] drvCnt_r;

  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////
  // period and drive-length counters; they saturate so a long idle never wraps
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      sclPrev_r <= 1'h1;
      seenRise_r <= 1'h0;
      periodCnt_r <= 8'h00;
      drvCnt_r <= 8'h00;
    end
    else
    begin
      sclPrev_r <= sclLine;
      if (sclLine && !sclPrev_r)
        seenRise_r <= 1'h1;
      if (sclLine && !sclPrev_r)
        periodCnt_r <= 8'h00;
      else if (periodCnt_r != 8'hFF)
        periodCnt_r <= periodCnt_r + 8'h01;
      if (!sdaDevOe)
        drvCnt_r <= 8'h00;
      else if (drvCnt_r != 8'hFF)
        drvCnt_r <= drvCnt_r + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // slave timing on the data line
  a_dev_no_start: assert property ($rose(sdaDevOe) |-> !sclLine)
    else $error("slave pulled data low while clock high");
  a_dev_no_stop: assert property ($fell(sdaDevOe) |-> !sclLine)
    else $error("slave released data while clock high");
  a_dev_high_stable: assert property ($rose(sclLine) |-> $stable(sdaDevOe)[*8])
    else $error("slave data moved during clock high");
  a_drive_after_fall: assert property ($rose(sdaDevOe) |->
    !$past(sclLine) && ($past(sclLine, 3) || $past(sclLine, 4) || $past(sclLine, 5)))
    else $error("slave drive not tied to a clock fall");
  a_release_after_fall: assert property ($fell(sdaDevOe) |->
    !$past(sclLine) && ($past(sclLine, 3) || $past(sclLine, 4) || $past(sclLine, 5)))
    else $error("slave release not tied to a clock fall");
  a_drive_len: assert property (drvCnt_r <= 8'hF0)
    else $error("slave held data low too long");
  // line-level rules for both ends
  a_stop_idle: assert property (
    $rose(sdaLine) && sclLine |-> (sdaLine && sclLine && !sclHostOe)[*8])
    else $error("bus not left idle after stop");
  a_scl_period: assert property (sclLine && !sclPrev_r && seenRise_r |->
    periodCnt_r >= 8'h18)
    else $error("serial clock period too short");
  a_scl_low_len: assert property ($fell(sclLine) |-> !sclLine[*8])
    else $error("serial clock low phase too short");
  a_sda_settled: assert property (
    $rose(sclLine) |-> $stable(sdaLine)[*3])
    else $error("data changed around clock rise");
endmodule

// [bench/testbench.sv]
/*
  Bench joining controller and reference slave over the shared interface.
  Software-level Wishbone tasks drive one byte on the link at a time; expectations are kept
  in two shadow banks of fourteen codes.
*/
`timescale 1ns/10ps
`define CHK(g, e) begin numChecks++; if ((g) !== (e)) begin badCount++; \
  $display("MISMATCH %0t got %0h exp %0h", $time, (g), (e)); end end
module testbench;
  import grp_pkg::*;
  localparam logic [3:0] ST = 4'h1;
  localparam logic [3:0] SP = 4'h2;
  localparam logic [3:0] RD = 4'h4;
  localparam logic [3:0] AK = 4'h8;
  logic clock = 1'h0;
  logic rst = 1'h1;
  logic cyc = 1'h0;
  logic stb = 1'h0;
  logic we = 1'h0;
  logic [3:0] adr = 4'h0;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] q;
  logic ack;
  logic modePin = 1'h1;
  logic adrPin = 1'h0;
  logic curvePin = 1'h0;
  logic [6:0][7:0] upperOut;
  logic [6:0][7:0] lowerOut;
  logic busy;
  logic [7:0] rxb;
  logic ackd;
  logic [7:0] bank0 [14];
  logic [7:0] bank1 [14];
  int badCount = 0;
  int numChecks = 0;

  grp_i2c_if bus();
  grp_bus_master i_grp_bus_master (.clock(clock), .rst(rst), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .dat_i(wdat), .sel_i(sel), .dat_o(rdat), .ack_o(ack), .bus(bus));
  grp_ref_slave i_grp_ref_slave (.clock(clock), .rst(rst), .bus(bus),
    .transferModePin(modePin), .addressLowBitPin(adrPin), .curveSelPin(curvePin),
    .upperRangeOutputs(upperOut), .lowerRangeOutputs(lowerOut), .busBusy(busy));
  grp_link_chk i_grp_link_chk (.clock(clock), .rst(rst), .sclHostOe(bus.sclHostOe),
    .sdaDevOe(bus.sdaDevOe), .sclLine(bus.sclLine), .sdaLine(bus.sdaLine));

  // 10 MHz system clock
  always #50 clock = ~clock;

  ////////////////////////////////////////////////////////////////////////////
  task automatic giveVerdict();
    if (badCount == 0 && numChecks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // a hung wait counts against the run and ends it
  task automatic timeOut();
    badCount++;
    $display("MISMATCH %0t wait ran out", $time);
    giveVerdict();
  endtask

  // one classic cycle; request held until ack is sampled high
  task automatic wbCycle(input logic w, input logic [3:0] a, input logic [31:0] d,
                         output logic [31:0] r);
    int n;
    @(posedge clock);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (ack !== 1'h1 && n < 20);
    r = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
    we <= 1'h0;
    if (n >= 20)
      timeOut();
  endtask

  // one byte on the link, then poll status until the controller is idle
  task automatic xfer(input logic [7:0] tx, input logic [3:0] fl, output logic [7:0] rx,
                      output logic ak);
    logic [31:0] r;
    int n;
    wbCycle(1'h1, CMD_OFS, {20'h0, fl, tx}, r);
    n = 0;
    do
    begin
      wbCycle(1'h0, STATUS_OFS, 32'h0, r);
      n++;
    end
    while (r[STS_BUSY_BIT] !== 1'h0 && n < 1000);
    if (n >= 1000)
      timeOut();
    rx = r[STS_RX_LSB +: 8];
    ak = r[STS_ACK_BIT];
  endtask

  task automatic sendW(input logic [7:0] tx, input logic [3:0] fl, input logic expAck);
    logic [7:0] rx;
    logic ak;
    xfer(tx, fl, rx, ak);
    `CHK(ak, expAck)
  endtask

  // pin passes sync flops, so allow a few clocks before looking
  task automatic checkOuts(input logic s);
    curvePin <= s;
    repeat (6) @(posedge clock);
    for (int i = 0; i < 7; i++)
    begin
      `CHK(upperOut[i], s ? bank1[i] : bank0[i])
      `CHK(lowerOut[i], s ? bank1[i + 7] : bank0[i + 7])
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    for (int i = 0; i < 14; i++)
    begin
      bank0[i] = 8'h00;
      bank1[i] = 8'h00;
    end
    repeat (2) @(posedge clock);
    rst <= 1'h0;
    repeat (4) @(posedge clock);
    `CHK(busy, 1'h0)
    `CHK({bus.sclLine, bus.sdaLine}, 2'h3)
    checkOuts(1'h0);
    wbCycle(1'h1, 4'h8, 32'h0000FFFF, q);
    wbCycle(1'h0, 4'h8, 32'h0, q);
    `CHK(q, 32'h0)
    // standard mode: all fourteen channels plus one surplus byte
    sendW(8'hE8, ST, 1'h1);
    `CHK(busy, 1'h1)
    sendW(8'h00, 4'h0, 1'h1);
    for (int k = 0; k < 15; k++)
    begin
      if (k < 14)
        bank0[k] = {4'(k), ~4'(k)};
      sendW({4'(k), ~4'(k)}, (k == 14) ? SP : 4'h0, 1'h1);
    end
    repeat (20) @(posedge clock);
    `CHK(busy, 1'h0)
    checkOuts(1'h0);
    // second bank written, first untouched
    sendW(8'hE8, ST, 1'h1);
    sendW(8'h02, 4'h0, 1'h1);
    bank1[0] = 8'hA5;
    bank1[1] = 8'h3C;
    sendW(8'hA5, 4'h0, 1'h1);
    sendW(8'h3C, SP, 1'h1);
    checkOuts(1'h1);
    checkOuts(1'h0);
    // foreign address: no acknowledge and nothing stored
    sendW(8'hEA, ST, 1'h0);
    sendW(8'h00, 4'h0, 1'h0);
    sendW(8'h55, SP, 1'h0);
    checkOuts(1'h0);
    adrPin <= 1'h1;
    repeat (4) @(posedge clock);
    sendW(8'hE8, ST | SP, 1'h0);
    sendW(8'hEA, ST, 1'h1);
    sendW(8'h00, 4'h0, 1'h1);
    bank0[0] = 8'h5A;
    sendW(8'h5A, SP, 1'h1);
    // read back the first three codes, last one refused by the master
    sendW(8'hEB, ST, 1'h1);
    for (int k = 0; k < 3; k++)
    begin
      xfer(8'hFF, (k == 2) ? (RD | SP) : (RD | AK), rxb, ackd);
      `CHK(rxb, bank0[k])
    end
    // register mode: pointer byte then data to pointer and onward
    modePin <= 1'h0;
    repeat (4) @(posedge clock);
    sendW(8'hEA, ST, 1'h1);
    sendW(8'h00, 4'h0, 1'h1);
    sendW(8'h09, 4'h0, 1'h1);
    bank0[9] = 8'hC3;
    bank0[10] = 8'h96;
    sendW(8'hC3, 4'h0, 1'h1);
    sendW(8'h96, SP, 1'h1);
    // register read starts at the pointer and takes the read bank bit
    sendW(8'hEA, ST, 1'h1);
    sendW(8'h04, 4'h0, 1'h1);
    sendW(8'h01, SP, 1'h1);
    sendW(8'hEB, ST, 1'h1);
    xfer(8'hFF, RD | SP, rxb, ackd);
    `CHK(rxb, bank1[1])
    checkOuts(1'h0);
    giveVerdict();
  end
endmodule
